//--- hw/sdsb_defs.svh
/*
 serial diagnostic status bytes: bit positions, reset values and timing counts.
 assumes a 40 MHz core clock shared by both ends.
*/
`ifndef SDSB_DEFS_SVH
`define SDSB_DEFS_SVH
`define SDSB_CHAIN_MAX        31
`define SDSB_REQ_MAGNET       0
`define SDSB_REQ_ERR_RESET    7
`define SDSB_RSP_OUT_ACTIVE   0
`define SDSB_RSP_LOCK_POSS    1
`define SDSB_RSP_LOCKED       2
`define SDSB_RSP_INPUTS_OK    4
`define SDSB_RSP_ACT_VALID    5
`define SDSB_RSP_WARNING      6
`define SDSB_RSP_ERROR        7
`define SDSB_DET_OUT_A        0
`define SDSB_DET_OUT_B        1
`define SDSB_DET_CROSS        2
`define SDSB_DET_TEMP         3
`define SDSB_DET_ACTUATOR     4
`define SDSB_DET_INTERNAL     5
`define SDSB_DET_COMM         6
`define SDSB_DET_HANDLE       7
`define SDSB_BYTE_RESET       8'h00
`define SDSB_WARN_MINUTES     30
`define SDSB_CLK_HZ           40000000
`define SDSB_WARN_CYCLES      (64'(`SDSB_WARN_MINUTES) * 64'd60 * 64'(`SDSB_CLK_HZ))
`define SDSB_COMM_TIMEOUT     16'h1000
`define SDSB_WARN_UNUSED      8'h10
`define SDSB_ERR_UNUSED       8'h40
`define SDSB_ADDR_REQ         2'h0
`define SDSB_ADDR_RSP         2'h1
`define SDSB_ADDR_WARN        2'h2
`define SDSB_ADDR_ERR         2'h3
`endif

//--- hw/sdsb_pkg.sv
/*
 types for the serial diagnostic status bytes.
 assumes sdsb_defs.svh for the numeric constants.
*/
package sdsb_pkg;
    typedef logic [7:0] sdsb_byte_t;
    typedef logic [4:0] sdsb_pos_t;
endpackage

//--- hw/sdsb_link_if.sv
/*
 link between the door lock device and the gateway: one chain position.
 assumes a single clock; the chain relay is carried as byte strobes.
*/
`timescale 1ns/1ps
interface sdsb_link_if;
    logic [7:0] req_byte;
    logic       req_valid;
    logic [7:0] rsp_byte;
    logic [7:0] warn_byte;
    logic [7:0] err_byte;
    logic       rsp_valid;
    modport dev (input req_byte, input req_valid,
                 output rsp_byte, output warn_byte, output err_byte, output rsp_valid);
    modport gw  (output req_byte, output req_valid,
                 input rsp_byte, input warn_byte, input err_byte, input rsp_valid);
endinterface

//--- hw/sdsb_device.sv
/*
 door lock device end: latches faults, tracks warnings unlatched, escalates warnings,
 reports status bytes each cycle and takes request bytes from the gateway.
 assumes fault and sensor inputs synchronous to core_clk.
*/
// Overview of operation
// [R1] chain holds at most 31 devices
// [R2] device relays diagnostic traffic along chain; this device has one link port and relays nothing
// [R3] status bytes refreshed continuously, automatically
// [R4] gateway sends one request byte per device
// [R5] link loss keeps switching state unchanged
// [R6] internal error switches both outputs off
// [R7] error clears: cause gone plus reset edge/open
// [R8] output faults stay latched until next release
// [R9] warning keeps outputs on, flags delayed shutdown
// [R10] warning clears itself when cause disappears
// [R11] warning held 30 minutes becomes error
// [R12] request bit 0 energises magnet
// [R13] response bits 0,1,2: outputs, lockable, locked
// [R14] response bit 4 inputs, bit 5 actuator
// [R15] response bit 6 warning, bit 7 error
// [R16] warning detail bit layout
// [R17] error detail bit layout
// [R18] lockable only when turret at rest
// [R19] request bits 1 to 6 ignored
`timescale 1ns/1ps
`include "sdsb_defs.svh"
module sdsb_device #(
    parameter logic [37:0] WARN_CYCLES = 38'(`SDSB_WARN_CYCLES)
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // link to gateway
    sdsb_link_if.dev  link,
    // plant sensing
    input  wire logic safety_input_a,
    input  wire logic safety_input_b,
    input  wire logic guard_closed,
    input  wire logic actuator_valid,
    input  wire logic turret_at_rest,
    input  wire logic output_release,
    // fault causes, level while present
    input  wire logic [7:0] fault_cause,
    input  wire logic [7:0] warn_cause,
    // plant outputs
    output logic      safety_output_a,
    output logic      safety_output_b,
    output logic      magnet_on
);
    // chain positions fit the 5-bit position type, so 31 at most
    localparam int unsigned CHAIN_MAX = `SDSB_CHAIN_MAX; // [R1]

    // latched and live fault state
    sdsb_pkg::sdsb_byte_t err_q;
    sdsb_pkg::sdsb_byte_t warn_q;
    logic [37:0]          warn_cnt_q;
    logic                 guard_q;
    // request side
    logic                 reset_bit_q;
    logic                 mag_q;
    logic [15:0]          comm_cnt_q;
    logic                 comm_lost_q;
    // plant and link side
    logic                 out_q;
    logic                 link_valid_q;
    sdsb_pkg::sdsb_byte_t rsp_q;
    sdsb_pkg::sdsb_byte_t warn_byte_q;
    sdsb_pkg::sdsb_byte_t err_byte_q;
    wire logic [7:0]      err_d;

    // detail bits 0 to 2 name the safety outputs; those clear only on release
    function automatic logic is_out_fault(input int unsigned idx);
        return idx <= `SDSB_DET_CROSS;
    endfunction

    // request decoding
    wire logic        req_reset_bit = link.req_byte[`SDSB_REQ_ERR_RESET];
    wire logic        reset_fall    = reset_bit_q & ~req_reset_bit & link.req_valid; // [R7]
    wire logic        guard_open    = guard_q & ~guard_closed;                        // [R7]
    wire logic        gen_clear     = reset_fall | guard_open;
    // warning timing; the count saturates so escalation holds while the cause stays
    wire logic        warn_any      = |warn_cause;
    wire logic        escalate      = warn_any && (warn_cnt_q >= WARN_CYCLES - 38'd1); // [R11]
    wire logic [37:0] warn_cnt_d    = !warn_any ? 38'h0 :
                                      escalate  ? warn_cnt_q : warn_cnt_q + 38'd1;
    wire logic [7:0]  new_err       = fault_cause | (escalate ? warn_cause : 8'h00);
    wire logic        err_any       = |err_q;
    // outputs and status
    wire logic        inputs_ok     = safety_input_a & safety_input_b;
    wire logic        enable        = inputs_ok & guard_closed & actuator_valid & ~err_any;
    wire logic        lockable      = guard_closed & turret_at_rest;                  // [R18]
    wire logic [7:0]  comm_bit      = 8'(comm_lost_q) << `SDSB_DET_COMM;
    wire logic [7:0]  warn_full     = warn_q | comm_bit;                              // [R16]

    // response byte, one wire per bit except bit 3, tied low
    wire logic        rsp_error     = err_any;                                        // [R15]
    wire logic        rsp_warning   = |warn_full;                                     // [R15]
    wire logic        rsp_act_ok    = actuator_valid;                                 // [R14]
    wire logic        rsp_inputs    = inputs_ok;                                      // [R14]
    wire logic        rsp_locked    = out_q & mag_q;                                  // [R13]
    wire logic        rsp_lock_ok   = lockable;                                       // [R13]
    wire logic        rsp_out_on    = out_q;                                          // [R13]
    wire logic [7:0]  rsp_d         = {rsp_error, rsp_warning, rsp_act_ok, rsp_inputs,
                                       1'b0, rsp_locked, rsp_lock_ok, rsp_out_on};

    // one latch cell per detail bit; set wins over clear in the same cycle
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_err_bit
            wire logic cause_gone = ~fault_cause[b];
            wire logic clr_out    = output_release & cause_gone; // [R8]
            wire logic clr_gen    = gen_clear & cause_gone;      // [R7]
            wire logic clr_b      = is_out_fault(b) ? clr_out : clr_gen;
            assign err_d[b] = new_err[b] | (err_q[b] & ~clr_b);
        end
    endgenerate

    // latched errors
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            err_q <= `SDSB_BYTE_RESET;
        end else begin
            err_q <= err_d;
        end
    end

    // warnings follow their cause, no latch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            warn_q     <= `SDSB_BYTE_RESET;
            warn_cnt_q <= 38'h0;
        end else begin
            warn_q     <= warn_cause & ~`SDSB_WARN_UNUSED; // [R10] [R16]
            warn_cnt_q <= warn_cnt_d;                       // [R11]
        end
    end

    // guard history for the opening edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            guard_q <= 1'b0;
        end else begin
            guard_q <= guard_closed;
        end
    end

    // request intake; bits 1 to 6 are never looked at
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reset_bit_q <= 1'b0;
            mag_q       <= 1'b0;
        end else if (link.req_valid) begin
            reset_bit_q <= req_reset_bit;                    // [R4]
            mag_q       <= link.req_byte[`SDSB_REQ_MAGNET]; // [R12] [R19]
        end
    end

    // link watchdog; a silent gateway changes nothing but the warning bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            comm_cnt_q  <= 16'h0;
            comm_lost_q <= 1'b0;
        end else if (link.req_valid) begin
            comm_cnt_q  <= 16'h0;
            comm_lost_q <= 1'b0;
        end else if (comm_cnt_q == `SDSB_COMM_TIMEOUT) begin
            comm_lost_q <= 1'b1; // [R5] magnet and outputs kept
        end else begin
            comm_cnt_q <= comm_cnt_q + 16'h1;
        end
    end

    // safety outputs drop in the same cycle as the error latches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
        end else begin
            out_q <= enable & ~(|new_err); // [R6] [R9]
        end
    end

    // status bytes registered every cycle, one set per chain position
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link_valid_q <= 1'b0;
            rsp_q        <= `SDSB_BYTE_RESET;
            warn_byte_q  <= `SDSB_BYTE_RESET;
            err_byte_q   <= `SDSB_BYTE_RESET;
        end else begin
            link_valid_q <= 1'b1;                            // [R2] [R3]
            rsp_q        <= rsp_d;                           // [R13] [R14] [R15]
            warn_byte_q  <= warn_full;                       // [R16]
            err_byte_q   <= err_q & ~`SDSB_ERR_UNUSED;       // [R17]
        end
    end

    // every output comes straight from a register
    assign link.rsp_valid  = link_valid_q; // [R3]
    assign link.rsp_byte   = rsp_q;
    assign link.warn_byte  = warn_byte_q;
    assign link.err_byte   = err_byte_q;
    assign safety_output_a = out_q;        // [R6]
    assign safety_output_b = out_q;
    assign magnet_on       = mag_q;        // [R12]
endmodule // sdsb_device

//--- hw/sdsb_gateway.sv
/*
 gateway end for one chain position: forwards the controller request byte
 and captures the status bytes for the controller.
 assumes a plain register port from the controller.
*/
`timescale 1ns/1ps
`include "sdsb_defs.svh"
module sdsb_gateway (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // link to device
    sdsb_link_if.gw   link,
    // controller port
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata
);
    logic [7:0] req_q, rsp_q, warn_q, err_q, rdata_q;
    logic       req_v_q;
    wire  logic [7:0] sel = (addr == `SDSB_ADDR_RSP)  ? rsp_q  :
                            (addr == `SDSB_ADDR_WARN) ? warn_q :
                            (addr == `SDSB_ADDR_ERR)  ? err_q  : req_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_q <= 8'h00; rsp_q <= 8'h00; warn_q <= 8'h00; err_q <= 8'h00;
            rdata_q <= 8'h00; req_v_q <= 1'b0;
        end else begin
            if (wr && addr == `SDSB_ADDR_REQ) req_q <= wdata; // [R4]
            req_v_q <= 1'b1;
            if (link.rsp_valid) begin
                rsp_q <= link.rsp_byte; warn_q <= link.warn_byte; err_q <= link.err_byte;
            end
            rdata_q <= rd ? sel : 8'h00;
        end
    end
    assign link.req_byte  = req_q;                     // [R12] [R7]
    assign link.req_valid = req_v_q;
    assign rdata          = rdata_q;
endmodule // sdsb_gateway

//--- bench/sdsb_link_sva.sv
/* checker on the link between device and gateway ends.
 assumes one clock and rst async high; placed beside the link. */
`timescale 1ns/1ps
module sdsb_link_sva (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // link signals
    input wire logic [7:0] req_byte,
    input wire logic       req_valid,
    input wire logic [7:0] rsp_byte,
    input wire logic [7:0] warn_byte,
    input wire logic [7:0] err_byte,
    input wire logic       rsp_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rsp_always_on: assert property (
        !$past(rst) |-> rsp_valid) else $error("status not valid");
    a_req_always_on: assert property (
        !$past(rst) |-> req_valid) else $error("request not sent");
    a_warn_flag_up: assert property (
        $rose(|warn_byte) |-> ##[0:2] rsp_byte[6]) else $error("warning flag missing");
    a_err_flag_up: assert property (
        $rose(|err_byte) |-> ##[0:2] rsp_byte[7]) else $error("error flag missing");
    a_err_kills_out: assert property (
        rsp_byte[7] [*3] |-> !rsp_byte[0]) else $error("outputs on during error");
    a_unused_detail: assert property (
        !warn_byte[4] && !err_byte[6]) else $error("unused detail bit set");
    a_locked_needs_out: assert property (
        rsp_byte[2] |-> rsp_byte[0]) else $error("locked without outputs");
    a_reset_clean: assert property (
        $fell(rst) |-> err_byte == 8'h00 && warn_byte == 8'h00) else $error("bytes not clear");
    // main scenarios reached
    c_error: cover property ($rose(rsp_byte[7]));
    c_warning: cover property ($rose(rsp_byte[6]));
    c_reset_edge: cover property ($fell(req_byte[7]));
endmodule // sdsb_link_sva

//--- bench/sdsb_link_tb.sv
/* bench for device and gateway ends joined by one link.
 assumes the defs header, package and link interface compiled first. */
`timescale 1ns/1ps
module sdsb_link_tb;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic [5:0] plant = 6'h00; // input a, b, guard, actuator, turret, release
    logic [7:0] fault_cause = 8'h00;
    logic [7:0] warn_cause = 8'h00;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] got;
    logic       out_a;
    logic       out_b;
    logic       magnet;
    int         err_count = 0;
    int         n_checks = 0;
    // bit 8 picks error over warning
    logic [8:0] rows [10] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h020, 9'h080,
                              9'h108, 9'h110, 9'h120, 9'h180};
    sdsb_link_if lnk ();
    always #12.5 core_clk = ~core_clk;
    // short escalation count keeps the run brief
    sdsb_device #(.WARN_CYCLES(38'd20)) i_sdsb_device (.core_clk(core_clk), .rst(rst),
        .link(lnk.dev), .safety_input_a(plant[5]), .safety_input_b(plant[4]),
        .guard_closed(plant[3]), .actuator_valid(plant[2]), .turret_at_rest(plant[1]),
        .output_release(plant[0]), .fault_cause(fault_cause), .warn_cause(warn_cause),
        .safety_output_a(out_a), .safety_output_b(out_b), .magnet_on(magnet));
    sdsb_gateway i_sdsb_gateway (.core_clk(core_clk), .rst(rst), .link(lnk.gw),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    sdsb_link_sva i_sdsb_link_sva (.core_clk(core_clk), .rst(rst), .req_byte(lnk.req_byte),
        .req_valid(lnk.req_valid), .rsp_byte(lnk.rsp_byte), .warn_byte(lnk.warn_byte),
        .err_byte(lnk.err_byte), .rsp_valid(lnk.rsp_valid));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr8(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rd8(input logic [1:0] a);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    // falling request bit 7 asks for an error reset
    task automatic clr();
        wr8(2'h0, 8'h80);
        wr8(2'h0, 8'h00);
        repeat (3) @(posedge core_clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge core_clk);
            if (rows[i][8]) fault_cause <= rows[i][7:0];
            else warn_cause <= rows[i][7:0];
            repeat (2) @(posedge core_clk);
            rd8({1'b1, rows[i][8]});
            chk(got, rows[i][7:0]);
            rd8(2'h1);
            chk(got & 8'hC0, rows[i][8] ? 8'h80 : 8'h40);
            @(posedge core_clk);
            fault_cause <= 8'h00;
            warn_cause <= 8'h00;
            clr();
            rd8({1'b1, rows[i][8]});
            chk(got, 8'h00);
        end
        // cause still present at the reset edge: bit 5 must survive
        @(posedge core_clk);
        fault_cause <= 8'h21;
        clr();
        @(posedge core_clk);
        fault_cause <= 8'h00;
        repeat (3) @(posedge core_clk);
        rd8(2'h3);
        chk(got, 8'h21);
        clr();
        rd8(2'h3);
        chk(got, 8'h01);
        @(posedge core_clk);
        plant <= 6'h01;
        @(posedge core_clk);
        plant <= 6'h00;
        repeat (3) @(posedge core_clk);
        rd8(2'h3);
        chk(got, 8'h00);
        @(posedge core_clk);
        warn_cause <= 8'h08;
        repeat (25) @(posedge core_clk);
        rd8(2'h3);
        chk(got, 8'h08);
        @(posedge core_clk);
        warn_cause <= 8'h00;
        plant <= 6'h3E;
        clr();
        wr8(2'h0, 8'h7F);
        repeat (2) @(posedge core_clk);
        chk({7'h0, magnet}, 8'h01);
        rd8(2'h1);
        chk(got & 8'h32, 8'h32);
        @(posedge core_clk);
        plant <= 6'h3C;
        wr8(2'h0, 8'h7E);
        repeat (3) @(posedge core_clk);
        chk({7'h0, magnet}, 8'h00);
        rd8(2'h1);
        chk(got & 8'h02, 8'h00);
        // warning keeps both outputs on, an error drops them
        @(posedge core_clk);
        plant <= 6'h3E;
        warn_cause <= 8'h04;
        repeat (4) @(posedge core_clk);
        chk({6'h0, out_a, out_b}, 8'h03);
        @(posedge core_clk);
        warn_cause <= 8'h00;
        fault_cause <= 8'h20;
        repeat (3) @(posedge core_clk);
        chk({6'h0, out_a, out_b}, 8'h00);
        // reset in mid-run clears the latch and lets the outputs back
        @(posedge core_clk);
        fault_cause <= 8'h00;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd8(2'h3);
        chk(got, 8'h00);
        chk({5'h0, out_a, out_b, magnet}, 8'h06);
        wrap_up();
    end
endmodule // sdsb_link_tb
